// *** common/uef_defines.svh ***
// Register offsets, field positions and sizes for the device event flag block
`ifndef UEF_DEFINES_SVH
`define UEF_DEFINES_SVH
`define UEF_ENG1_FLAGS_ADDR 16'hc090
`define UEF_ENG2_FLAGS_ADDR 16'hc0b0
`define UEF_ENG1_ENABLE_ADDR 16'hc08c
`define UEF_ENG2_ENABLE_ADDR 16'hc0ac
`define UEF_ENG1_EPNAK_ADDR 16'hc0c0
`define UEF_ENG2_EPNAK_ADDR 16'hc0c2
`define UEF_BIT_VBUS 15
`define UEF_BIT_ID 14
`define UEF_BIT_FRAME 9
`define UEF_BIT_BUSRST 8
`define UEF_NUM_EP 8
`define UEF_FLAG_RESET 16'h0000
`define UEF_ENG1_MASK 16'hc3ff
`define UEF_ENG2_MASK 16'h03ff
`endif

// *** common/uef_pkg.sv ***
// Types shared by the device event flag block
package uef_pkg;
   // One engine's event inputs for one clock cycle, all single-cycle pulses
   typedef struct packed {
      logic vbusEdge;
      logic idEdge;
      logic frameRx;
      logic busReset;
      logic [7:0] epDone;
      logic [7:0] epNak;
   } uef_events_t;
   // Register access from either processor
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } uef_access_t;
endpackage : uef_pkg

// *** design/uef_flag_bank.sv ***
// One engine's event flag register with write-one-to-clear and enable gating
`timescale 1ns/100ps
`include "uef_defines.svh"
module uef_flag_bank #(
   parameter logic [15:0] IMPL_MASK = `UEF_ENG1_MASK
) (
   input wire logic clk_sys, // System clock
   input wire logic srst, // Synchronous reset, high
   input wire uef_pkg::uef_events_t ev, // Event pulses
   input wire logic [7:0] nakEnable, // Per-endpoint NAK event enable
   input wire logic [15:0] intEnable, // Companion enable register
   input wire logic clrStrobe, // Write to this flag register
   input wire logic [15:0] clrData, // Write data, ones clear
   output logic [15:0] flags, // Flag register contents
   output logic intPending // Any enabled flag set
);
   logic [15:0] flags_q;
   logic [15:0] setVec;
   logic [15:0] clrVec;

   always_comb
   begin
      setVec = 16'h0000;
      setVec[`UEF_BIT_VBUS] = ev.vbusEdge;
      setVec[`UEF_BIT_ID] = ev.idEdge;
      setVec[`UEF_BIT_FRAME] = ev.frameRx;
      setVec[`UEF_BIT_BUSRST] = ev.busReset;
      setVec[7:0] = ev.epDone | (ev.epNak & nakEnable);
      // Events only latch when their enable is set
      setVec = setVec & intEnable & IMPL_MASK;
      clrVec = clrStrobe ? clrData : 16'h0000;
   end

   // Set wins over a clear landing in the same cycle
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         flags_q <= `UEF_FLAG_RESET;
      else
         flags_q <= (flags_q & ~clrVec) | setVec;
   end

   assign flags = flags_q;
   assign intPending = |(flags_q & intEnable);
endmodule : uef_flag_bank

// *** design/usb_event_flags.sv ***
// Two engines' event flag registers reached by on-chip and host-port processors
`timescale 1ns/100ps
`include "uef_defines.svh"
// Operation
// - Two flag registers, first engine at 0xC090, second at 0xC0B0.
// - Writing one clears a flag; writing zero leaves it alone.
// - Parallel host port reads and writes flags like the on-chip processor.
// - Bit 15 sets on either crossing of bus supply voltage when enabled.
// - Bit 14 sets on either edge of the OTG ID pin when enabled.
// - Supply and ID flags exist only for the first engine.
// - Second engine bits 15 and 14 are reserved, no flag function.
// - Bit 9 sets on start-of-frame or end-of-packet reception.
// - Bit 8 sets when a USB bus reset is detected.
// - Bits 7..0 flag transaction done on endpoints seven to zero.
// - With endpoint NAK enable set, a NAK answer also sets the flag.
// - Each flag is gated by the same bit of the enable register.
module usb_event_flags (
   input wire logic clk_sys, // System clock, 10 MHz
   input wire logic srst, // Synchronous reset, high
   input wire uef_pkg::uef_access_t cpuAcc, // On-chip processor access
   output logic [15:0] cpuRdata, // On-chip read data
   input wire uef_pkg::uef_access_t hostAcc, // Parallel host port access
   output logic [15:0] hostRdata, // Host port read data
   input wire uef_pkg::uef_events_t eng1Ev, // First engine events
   input wire uef_pkg::uef_events_t eng2Ev, // Second engine events
   output logic eng1Int, // First engine interrupt request
   output logic eng2Int // Second engine interrupt request
);
   logic [15:0] en1_q;
   logic [15:0] en2_q;
   logic [7:0] nak1_q;
   logic [7:0] nak2_q;
   logic [15:0] flags1;
   logic [15:0] flags2;
   logic [15:0] cpuRdata_q;
   logic [15:0] hostRdata_q;
   logic clr1;
   logic clr2;
   logic [15:0] clr1Data;
   logic [15:0] clr2Data;

   function automatic logic hit(input uef_pkg::uef_access_t a, input logic [15:0] addr);
      hit = a.wr && (a.addr == addr);
   endfunction : hit

   function automatic logic [15:0] readMux(input logic [15:0] addr, input logic [15:0] f1,
      input logic [15:0] f2, input logic [15:0] e1, input logic [15:0] e2,
      input logic [7:0] n1, input logic [7:0] n2);
      case (addr)
         `UEF_ENG1_FLAGS_ADDR: readMux = f1;
         `UEF_ENG2_FLAGS_ADDR: readMux = f2;
         `UEF_ENG1_ENABLE_ADDR: readMux = e1;
         `UEF_ENG2_ENABLE_ADDR: readMux = e2;
         `UEF_ENG1_EPNAK_ADDR: readMux = {8'h00, n1};
         `UEF_ENG2_EPNAK_ADDR: readMux = {8'h00, n2};
         default: readMux = 16'h0000;
      endcase
   endfunction : readMux

   // Both processors may clear in one cycle; their ones are merged
   always_comb
   begin
      clr1 = hit(cpuAcc, `UEF_ENG1_FLAGS_ADDR) || hit(hostAcc, `UEF_ENG1_FLAGS_ADDR);
      clr2 = hit(cpuAcc, `UEF_ENG2_FLAGS_ADDR) || hit(hostAcc, `UEF_ENG2_FLAGS_ADDR);
      clr1Data = (hit(cpuAcc, `UEF_ENG1_FLAGS_ADDR) ? cpuAcc.wdata : 16'h0000)
         | (hit(hostAcc, `UEF_ENG1_FLAGS_ADDR) ? hostAcc.wdata : 16'h0000);
      clr2Data = (hit(cpuAcc, `UEF_ENG2_FLAGS_ADDR) ? cpuAcc.wdata : 16'h0000)
         | (hit(hostAcc, `UEF_ENG2_FLAGS_ADDR) ? hostAcc.wdata : 16'h0000);
   end

   // Register map, engine 1 / engine 2:
   //   flags: c090 / c0b0, a one written clears that flag
   //   enables: c08c / c0ac, same bit layout as the flags
   //   NAK enables: c0c0 / c0c2, one bit per endpoint in the low byte
   // Any other address reads zero and ignores writes. Enables reset to zero,
   // so no flag can latch until firmware opts in.

   // Flag bits: 15 supply crossing and 14 ID edge (engine 1 only), 13..10
   // reserved, 9 start-of-frame or end-of-packet, 8 bus reset, 7..0 endpoint
   // transaction done, which a NAK answer also sets when that endpoint's NAK
   // enable is on.

   // Simultaneous access from both processors:
   //   flag register: the ones of both writes merge, so neither clear is lost
   //   enable or NAK register: the host port's word is kept
   //   reads: each port has its own data register and never waits on the other

   // srst clears every register here on the next edge; flags come up clear,
   // though firmware should acknowledge everything before it trusts them
   localparam logic [15:0] ENG1_IMPL = `UEF_ENG1_MASK;
   localparam logic [15:0] ENG2_IMPL = `UEF_ENG2_MASK;

   // Engine 2 sits on a port with no OTG sensing; its supply and ID edges are
   // dropped here, and the bank's implemented-bit mask drops them once more
   uef_pkg::uef_events_t eng1EvQual;
   uef_pkg::uef_events_t eng2EvQual;

   always_comb
   begin
      eng1EvQual = eng1Ev;
      eng2EvQual = eng2Ev;
      eng2EvQual.vbusEdge = 1'b0;
      eng2EvQual.idEdge = 1'b0;
   end

   // Ones written to reserved bits are dropped before a bank sees them, so a
   // careless write cannot reach a bit that has no flag behind it
   logic [15:0] clr1Word;
   logic [15:0] clr2Word;

   always_comb
   begin
      clr1Word = clr1Data & ENG1_IMPL;
      clr2Word = clr2Data & ENG2_IMPL;
   end

   // Host port wins a tie on an enable register, so a supervisor on the host
   // side is never overruled by firmware writing in the same cycle
   function automatic logic [15:0] enSel(input uef_pkg::uef_access_t h,
      input uef_pkg::uef_access_t c, input logic [15:0] addr, input logic [15:0] old);
      if (hit(h, addr))
         enSel = h.wdata;
      else if (hit(c, addr))
         enSel = c.wdata;
      else
         enSel = old;
   endfunction : enSel

   // First engine enable register; bits with no flag behind them never stick,
   // so a readback shows exactly what can latch
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         en1_q <= 16'h0000;
      else
         en1_q <= enSel(hostAcc, cpuAcc, `UEF_ENG1_ENABLE_ADDR, en1_q) & ENG1_IMPL;
   end

   // Second engine enable register; the OTG pair always reads back zero
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         en2_q <= 16'h0000;
      else
         en2_q <= enSel(hostAcc, cpuAcc, `UEF_ENG2_ENABLE_ADDR, en2_q) & ENG2_IMPL;
   end

   // First engine NAK enables; only the low byte exists, one bit per endpoint
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         nak1_q <= 8'h00;
      else
         nak1_q <= 8'(enSel(hostAcc, cpuAcc, `UEF_ENG1_EPNAK_ADDR, {8'h00, nak1_q}));
   end

   // Second engine NAK enables
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         nak2_q <= 8'h00;
      else
         nak2_q <= 8'(enSel(hostAcc, cpuAcc, `UEF_ENG2_EPNAK_ADDR, {8'h00, nak2_q}));
   end

   // An event is taken on the edge where its pulse and enable are both high; the
   // flag and the interrupt level appear together one cycle later. A disabled
   // event is dropped, not remembered for a later enable.
   uef_flag_bank #(.IMPL_MASK(ENG1_IMPL)) bank1 (
      .clk_sys(clk_sys),
      .srst(srst),
      .ev(eng1EvQual),
      .nakEnable(nak1_q),
      .intEnable(en1_q),
      .clrStrobe(clr1),
      .clrData(clr1Word),
      .flags(flags1),
      .intPending(eng1Int)
   );

   // Second engine has no OTG port, so its top two bits are masked off
   uef_flag_bank #(.IMPL_MASK(ENG2_IMPL)) bank2 (
      .clk_sys(clk_sys),
      .srst(srst),
      .ev(eng2EvQual),
      .nakEnable(nak2_q),
      .intEnable(en2_q),
      .clrStrobe(clr2),
      .clrData(clr2Word),
      .flags(flags2),
      .intPending(eng2Int)
   );

   // On-chip read data holds until the next on-chip read. A read and a clear of
   // the same flag register in one cycle return the word from before the clear.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         cpuRdata_q <= 16'h0000;
      else if (cpuAcc.rd)
         cpuRdata_q <= readMux(cpuAcc.addr, flags1, flags2, en1_q, en2_q, nak1_q,
            nak2_q);
   end

   // Host port read data, decoded exactly as the on-chip path
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         hostRdata_q <= 16'h0000;
      else if (hostAcc.rd)
         hostRdata_q <= readMux(hostAcc.addr, flags1, flags2, en1_q, en2_q, nak1_q,
            nak2_q);
   end

   // Interrupt requests are levels from the banks, high while any enabled
   // flag is set; they need no acknowledge of their own
   assign cpuRdata = cpuRdata_q;
   assign hostRdata = hostRdata_q;
endmodule : usb_event_flags

// *** sim/tb_top.sv ***
// Random self-checking bench for the event flag block
`timescale 1ns/100ps
module tb_top;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   uef_pkg::uef_access_t cpuAcc = '0;
   uef_pkg::uef_access_t hostAcc = '0;
   uef_pkg::uef_events_t eng1Ev, eng2Ev;
   logic [15:0] cpuRdata, hostRdata, f1, f2, e1, e2, xc, xh;
   logic [7:0] n1, n2;
   logic eng1Int, eng2Int;
   logic [15:0] ad [8] = '{16'hc090, 16'hc0b0, 16'hc08c, 16'hc0ac, 16'hc0c0, 16'hc0c2,
      16'hc092, 16'hc0a0};
   int miscompares = 0;
   int n_compared = 0;
   initial forever #50 clk_sys = ~clk_sys;
   usb_event_flags dut (.clk_sys(clk_sys), .srst(srst), .cpuAcc(cpuAcc), .cpuRdata(cpuRdata),
      .hostAcc(hostAcc), .hostRdata(hostRdata), .eng1Ev(eng1Ev), .eng2Ev(eng2Ev),
      .eng1Int(eng1Int), .eng2Int(eng2Int));
   uef_sie_model sie (.clk_sys(clk_sys), .run(!srst), .ev1(eng1Ev), .ev2(eng2Ev));
   function automatic logic [15:0] rdv(logic [15:0] a);
      case (a)
         16'hc090: return f1;
         16'hc0b0: return f2;
         16'hc08c: return e1;
         16'hc0ac: return e2;
         16'hc0c0: return {8'h00, n1};
         16'hc0c2: return {8'h00, n2};
         default: return 16'h0000;
      endcase
   endfunction : rdv
   function automatic logic [15:0] setv(uef_pkg::uef_events_t v, logic [7:0] n);
      return {v.vbusEdge, v.idEdge, 4'h0, v.frameRx, v.busReset, v.epDone | (v.epNak & n)};
   endfunction : setv
   function automatic logic [15:0] clrv(logic [15:0] a);
      return (cpuAcc.wr && cpuAcc.addr == a ? cpuAcc.wdata : 16'h0000)
         | (hostAcc.wr && hostAcc.addr == a ? hostAcc.wdata : 16'h0000);
   endfunction : clrv
   // Host wins when both ports write one enable register together
   function automatic logic [15:0] wen(logic [15:0] a, logic [15:0] old);
      return hostAcc.wr && hostAcc.addr == a ? hostAcc.wdata
         : (cpuAcc.wr && cpuAcc.addr == a ? cpuAcc.wdata : old);
   endfunction : wen
   function automatic uef_pkg::uef_access_t rnd();
      uef_pkg::uef_access_t a;
      a.wr = $urandom_range(3) == 0;
      a.rd = !a.wr && $urandom_range(1);
      a.addr = ad[$urandom_range(7)];
      a.wdata = 16'($urandom);
      return a;
   endfunction : rnd
   always @(posedge clk_sys)
   begin
      if (srst)
         {f1, f2, e1, e2, n1, n2, xc, xh} <= '0;
      else
      begin
         if (cpuAcc.rd) xc <= rdv(cpuAcc.addr);
         if (hostAcc.rd) xh <= rdv(hostAcc.addr);
         f1 <= (f1 & ~clrv(16'hc090)) | (setv(eng1Ev, n1) & e1 & 16'hc3ff);
         f2 <= (f2 & ~clrv(16'hc0b0)) | (setv(eng2Ev, n2) & e2 & 16'h03ff);
         e1 <= wen(16'hc08c, e1) & 16'hc3ff;
         e2 <= wen(16'hc0ac, e2) & 16'h03ff;
         n1 <= 8'(wen(16'hc0c0, {8'h00, n1}));
         n2 <= 8'(wen(16'hc0c2, {8'h00, n2}));
      end
   end
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   always @(negedge clk_sys)
   begin
      if (!srst)
      begin
         chk(cpuRdata, xc);
         chk(hostRdata, xh);
         chk({14'h0, eng1Int, eng2Int}, {14'h0, |(f1 & e1), |(f2 & e2)});
      end
   end
   task automatic tally_and_finish();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      void'($urandom(32'ha6facfb0));
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      for (int i = 0; i < 3000; i++)
      begin
         @(posedge clk_sys);
         cpuAcc <= (i == 0) ? uef_pkg::uef_access_t'{1'b1, 1'b0, 16'hc08c, 16'hffff} : rnd();
         hostAcc <= (i == 0) ? uef_pkg::uef_access_t'{1'b1, 1'b0, 16'hc0ac, 16'hffff} : rnd();
         srst <= i inside {[1500:1502]};
      end
      tally_and_finish();
   end
endmodule : tb_top

// *** sim/uef_flags_sva.sv ***
// Port-level assertions for the event flag block
`timescale 1ns/100ps
module uef_flags_sva (
   input wire logic clk_sys, // Clock
   input wire logic srst, // Reset
   input wire uef_pkg::uef_access_t cpuAcc, // Cpu bus
   input wire logic [15:0] cpuRdata, // Cpu data
   input wire uef_pkg::uef_access_t hostAcc, // Host bus
   input wire logic [15:0] hostRdata, // Host data
   input wire uef_pkg::uef_events_t eng1Ev, // Events 1
   input wire uef_pkg::uef_events_t eng2Ev, // Events 2
   input wire logic eng1Int, // Int 1
   input wire logic eng2Int // Int 2
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   function automatic logic mp(logic [15:0] a);
      return a inside {16'hc090, 16'hc0b0, 16'hc08c, 16'hc0ac, 16'hc0c0, 16'hc0c2};
   endfunction : mp
   sequence rdCpu(a);
      cpuAcc.rd && cpuAcc.addr == a;
   endsequence
   sequence noWr;
      !cpuAcc.wr && !hostAcc.wr;
   endsequence
   cpu_unmap_a: assert property (cpuAcc.rd && !mp(cpuAcc.addr) |=> cpuRdata == 16'h0000)
      else $error("cpu unmapped read not zero");
   host_unmap_a: assert property (hostAcc.rd && !mp(hostAcc.addr) |=> hostRdata == 16'h0000)
      else $error("host unmapped read not zero");
   eng1_resv_a: assert property (rdCpu(16'hc090) |=> cpuRdata[13:10] == 4'h0)
      else $error("engine 1 reserved bits set");
   eng2_resv_a: assert property (rdCpu(16'hc0b0) |=> cpuRdata[15:10] == 6'h00)
      else $error("engine 2 reserved bits set");
   rdata_hold_a: assert property (!cpuAcc.rd |=> $stable(cpuRdata))
      else $error("cpu read data moved");
   int1_hold_a: assert property (eng1Int ##0 noWr |=> eng1Int)
      else $error("engine 1 request dropped");
   int2_hold_a: assert property (eng2Int ##0 noWr |=> eng2Int)
      else $error("engine 2 request dropped");
   dual_read_a: assert property (cpuAcc.rd && hostAcc.rd && cpuAcc.addr == hostAcc.addr
      |=> cpuRdata == hostRdata) else $error("ports read differently");
   logic eng2Quiet;
   assign eng2Quiet = {eng2Ev.frameRx, eng2Ev.busReset, eng2Ev.epDone, eng2Ev.epNak} == 18'h0;
   int1_cause_a: assert property ((!eng1Int && eng1Ev == '0) ##0 noWr |=> !eng1Int)
      else $error("engine 1 request with no cause");
   eng2_otg_a: assert property ((!eng2Int && eng2Quiet) ##0 noWr |=> !eng2Int)
      else $error("engine 2 request from OTG edge");
endmodule : uef_flags_sva
bind usb_event_flags uef_flags_sva chk (.clk_sys(clk_sys), .srst(srst), .cpuAcc(cpuAcc),
   .cpuRdata(cpuRdata), .hostAcc(hostAcc), .hostRdata(hostRdata), .eng1Ev(eng1Ev),
   .eng2Ev(eng2Ev), .eng1Int(eng1Int), .eng2Int(eng2Int));

// *** sim/uef_sie_model.sv ***
// Event source standing in for both serial interface engines
`timescale 1ns/100ps
module uef_sie_model (
   input wire logic clk_sys, // Clock
   input wire logic run, // Emit when high
   output uef_pkg::uef_events_t ev1 = '0, // Engine 1 pulses
   output uef_pkg::uef_events_t ev2 = '0 // Engine 2 pulses
);
   // Sparse pulses keep clears visible; engine 2 also pulses supply and ID lines
   always @(posedge clk_sys)
   begin
      ev1 <= run ? 20'($urandom & $urandom & $urandom) : '0;
      ev2 <= run ? 20'($urandom & $urandom & $urandom) : '0;
   end
endmodule : uef_sie_model
